// [adc_seq_defs.svh]
// constants for the conversion sequencer
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define OFS_MODE      8'h00
`define OFS_CHAN      8'h04
`define OFS_RESULT    8'h08
`define OFS_RESULT_HI 8'h0c
`define OFS_STATUS    8'h10
`define OFS_MASK      8'h14
`define OFS_ANALOG    8'h18
`define MODE_RUN_BIT  7
`define MODE_CMP_BIT  0
`define STAT_DONE_BIT 0
`define STAT_BAD_BIT  1
`define ENABLE_SETTLE_NS 1000
`define CLK_PERIOD_NS    10
`define SETTLE_CYCLES    ((`ENABLE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYCLES_DEF  44
`define RESULT_BITS   10
`endif

// [adc_seq_pkg.sv]
// types for the conversion sequencer
package adc_seq_pkg;
	typedef enum logic [1:0] {st_idle, st_sample, st_convert} conv_state_type;
	typedef struct packed {
		logic       sel;
		logic       write;
		logic [7:0] addr;
	} bus_req_type;
	typedef struct packed {
		logic [9:0] value;
		logic       first_suspect;
	} result_type;
endpackage : adc_seq_pkg

// [adc_conversion_sequencer.sv]
// ahb-lite control logic of a four channel 10 bit sar converter
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_defs.svh"

module adc_conversion_sequencer #(
	parameter int conv_cycles = `CONV_CYCLES_DEF
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [9:0]  sar_sample,
	output logic      [1:0]  analog_channel,
	output logic             comparator_on,
	output logic             conversion_done_interrupt
);
	localparam int settle_cycles = `SETTLE_CYCLES;

	// ==========================================================
	// bus address phase capture
	adc_seq_pkg::bus_req_type req;
	adc_seq_pkg::bus_req_type next_req;
	always_comb begin
		next_req.sel   = hsel & hready & htrans[1];
		next_req.write = hwrite;
		next_req.addr  = haddr[7:0];
	end

	// data phase decodes
	logic wr_mode, wr_chan, wr_stat, wr_mask, rd_result;
	always_comb begin
		wr_mode   = req.sel & req.write & (req.addr == `OFS_MODE);
		wr_chan   = req.sel & req.write & (req.addr == `OFS_CHAN);
		wr_stat   = req.sel & req.write & (req.addr == `OFS_STATUS);
		wr_mask   = req.sel & req.write & (req.addr == `OFS_MASK);
		rd_result = req.sel & ~req.write & ((req.addr == `OFS_RESULT) | (req.addr == `OFS_RESULT_HI));
	end

	// ==========================================================
	// register and sequencer state
	logic [7:0]  mode, next_mode;
	logic [1:0]  chan, next_chan;
	logic [1:0]  stat, next_stat;
	logic [1:0]  mask, next_mask;
	adc_seq_pkg::result_type result, next_result;
	adc_seq_pkg::result_type pending, next_pending;
	logic        hold, next_hold;
	logic        first_pend, next_first_pend;
	logic        suspect, next_suspect;
	logic [7:0]  settle, next_settle;
	logic [15:0] count, next_count;
	adc_seq_pkg::conv_state_type state, next_state;
	logic [31:0] next_hrdata;
	logic        conv_end;
	logic        run, cmp;

	always_comb begin
		run = mode[`MODE_RUN_BIT];
		cmp = mode[`MODE_CMP_BIT];
	end

	// sequencer: 1 sample cycle then a counted conversion; a stop aborts at once
	always_comb begin
		next_state = state;
		next_count = count;
		conv_end   = 1'b0;
		case (state)
			adc_seq_pkg::st_idle: begin
				if (run) begin
					next_state = adc_seq_pkg::st_sample;
					next_count = 16'h0000;
				end
			end
			adc_seq_pkg::st_sample: begin
				next_state = adc_seq_pkg::st_convert;
			end
			adc_seq_pkg::st_convert: begin
				if (count >= 16'(conv_cycles - 1)) begin
					conv_end   = 1'b1;
					next_count = 16'h0000;
					next_state = adc_seq_pkg::st_sample; // continuous conversion while run stays set
				end else begin
					next_count = count + 16'h0001;
				end
			end
			default: next_state = adc_seq_pkg::st_idle;
		endcase
		if (!run) begin
			next_state = adc_seq_pkg::st_idle;
		end
	end

	// registers, flags and result storage
	always_comb begin
		next_mode       = mode;
		next_chan       = chan;
		next_mask       = mask;
		next_stat       = stat;
		next_result     = result;
		next_pending    = pending;
		next_hold       = hold;
		next_first_pend = first_pend;
		next_suspect    = suspect;
		next_settle     = settle;
		next_hrdata     = 32'h0000_0000;
		// enable settle timer
		if (!cmp) begin
			next_settle = 8'h00;
		end else if (settle < 8'(settle_cycles)) begin
			next_settle = settle + 8'h01;
		end
		if (wr_mode) begin
			next_mode = hwdata[7:0];
			// a fresh start judges the first result against the enable spacing
			if (hwdata[`MODE_RUN_BIT] && !run) begin
				next_first_pend = 1'b1;
				next_suspect    = !hwdata[`MODE_CMP_BIT] || !cmp || (settle < 8'(settle_cycles));
			end
		end
		if (wr_chan) begin
			next_chan = hwdata[1:0];
		end
		if (wr_mask) begin
			next_mask = hwdata[1:0];
		end
		if (wr_stat) begin
			next_stat = stat & ~hwdata[1:0];
		end
		// end of conversion unless a mode or channel write coincides; a cancelled end leaves the
		// result registers as they were, which software must treat as undefined after such a write
		// an end one cycle before a channel write still stores the old channel's result and flag
		if (conv_end && !(wr_mode || wr_chan)) begin
			next_pending.value         = sar_sample;
			next_pending.first_suspect = first_pend & suspect;
			next_first_pend            = 1'b0;
			next_hold                  = 1'b1;
			next_stat[`STAT_DONE_BIT]  = 1'b1;
			next_stat[`STAT_BAD_BIT]   = next_stat[`STAT_BAD_BIT] | (first_pend & suspect); // sticky, set wins
		end
		// stored result moves in after any result read in progress has finished
		if (hold && !rd_result) begin
			next_result = pending;
			next_hold   = 1'b0;
		end
		// read mux for the next data phase
		if (next_req.sel && !hwrite) begin
			case (haddr[7:0])
				`OFS_MODE:      next_hrdata = {24'h000000, mode};
				`OFS_CHAN:      next_hrdata = {30'h0, chan};
				`OFS_RESULT:    next_hrdata = {16'h0000, result.value, 6'h00};
				`OFS_RESULT_HI: next_hrdata = {24'h000000, result.value[9:2]};
				`OFS_STATUS:    next_hrdata = {30'h0, stat};
				`OFS_MASK:      next_hrdata = {30'h0, mask};
				default:        next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			req        <= '0;
			mode       <= 8'h00;
			chan       <= 2'h0;
			stat       <= 2'h0;
			mask       <= 2'h0;
			result     <= '0;
			pending    <= '0;
			hold       <= 1'b0;
			first_pend <= 1'b0;
			suspect    <= 1'b0;
			settle     <= 8'h00;
			count      <= 16'h0000;
			state      <= adc_seq_pkg::st_idle;
			hrdata     <= 32'h0000_0000;
		end else begin
			req        <= next_req;
			mode       <= next_mode;
			chan       <= next_chan;
			stat       <= next_stat;
			mask       <= next_mask;
			result     <= next_result;
			pending    <= next_pending;
			hold       <= next_hold;
			first_pend <= next_first_pend;
			suspect    <= next_suspect;
			settle     <= next_settle;
			count      <= next_count;
			state      <= next_state;
			hrdata     <= next_hrdata;
		end
	end

	// ==========================================================
	// outputs, all registered; slave is always ready and okay
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hreadyout                 <= 1'b1;
			hresp                     <= 1'b0;
			analog_channel            <= 2'h0;
			comparator_on             <= 1'b0;
			conversion_done_interrupt <= 1'b0;
		end else begin
			hreadyout                 <= 1'b1;
			hresp                     <= 1'b0;
			analog_channel            <= next_chan;
			comparator_on             <= next_mode[`MODE_CMP_BIT];
			conversion_done_interrupt <= |(next_stat & next_mask);
		end
	end

	// ==========================================================
	// checks
	a_write_wins: assert property (@(posedge ref_clk) disable iff (!nrst)
		conv_end && (wr_mode || wr_chan) && !stat[`STAT_DONE_BIT] && !wr_stat |=> !stat[`STAT_DONE_BIT])
		else $error("done flag set despite coinciding register write");
	a_chan_keeps_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
		wr_chan && !conv_end && !wr_stat |=> stat[`STAT_DONE_BIT] == $past(stat[`STAT_DONE_BIT]))
		else $error("channel write changed the done flag");
	a_done_sets_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
		conv_end && !(wr_mode || wr_chan) |=> stat[`STAT_DONE_BIT])
		else $error("normal end did not set done flag");
	a_done_irq: assert property (@(posedge ref_clk) disable iff (!nrst)
		conv_end && !(wr_mode || wr_chan) && mask[`STAT_DONE_BIT] && !wr_mask |=> conversion_done_interrupt)
		else $error("unmasked done did not raise interrupt");
	a_read_first: assert property (@(posedge ref_clk) disable iff (!nrst)
		hold && rd_result |=> result == $past(result))
		else $error("result changed during a read");
	a_stop_idles: assert property (@(posedge ref_clk) disable iff (!nrst)
		!run |=> state == adc_seq_pkg::st_idle)
		else $error("sequencer running with run bit clear");
	a_suspect_start: assert property (@(posedge ref_clk) disable iff (!nrst)
		wr_mode && hwdata[`MODE_RUN_BIT] && !run && !cmp |=> suspect)
		else $error("start without enable not marked suspect");
	a_result_source: assert property (@(posedge ref_clk) disable iff (!nrst)
		conv_end && !(wr_mode || wr_chan) |=> pending.value == $past(sar_sample))
		else $error("stored result differs from sample");
	c_normal_end: cover property (@(posedge ref_clk) disable iff (!nrst) conv_end && !(wr_mode || wr_chan));
	c_conflict_end: cover property (@(posedge ref_clk) disable iff (!nrst) conv_end && wr_chan);
	c_read_clash: cover property (@(posedge ref_clk) disable iff (!nrst) hold && rd_result);
	c_suspect_first: cover property (@(posedge ref_clk) disable iff (!nrst) conv_end && first_pend && suspect);
endmodule : adc_conversion_sequencer
`default_nettype wire

// [analog_core_model.sv]
// behavioural model of the analog core that feeds the sequencer
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// analog core model
module analog_core_model (
	input  wire logic [1:0] analog_channel,
	input  wire logic       comparator_on,
	output logic      [9:0] sar_sample
);
	// each channel gives its own code; with the comparator off the code is inverted, never a kind value
	assign sar_sample = comparator_on ? {analog_channel, 8'h3c} : ~{analog_channel, 8'h3c};
endmodule : analog_core_model
`default_nettype wire

// [testbench.sv]
// self-checking testbench of the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_defs.svh"
module testbench;
	logic        ref_clk, nrst, hsel, hwrite, hreadyout, hresp, comparator_on, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, analog_channel;
	logic [2:0]  hsize;
	logic [9:0]  sar_sample;
	int          n_errors, n_tests, cycles;
	// ==========================================
	// design and analog core
	adc_conversion_sequencer #(.conv_cycles(4)) DUT (
		.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .sar_sample(sar_sample), .analog_channel(analog_channel),
		.comparator_on(comparator_on), .conversion_done_interrupt(irq));
	analog_core_model core (.analog_channel(analog_channel), .comparator_on(comparator_on),
		.sar_sample(sar_sample));
	// ==========================================
	// clock and hang guard
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// a hung handshake ends the run here instead of running forever
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors = n_errors + 1;
			complete_run();
		end
	end
	// ==========================================
	// bus tasks and checks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk
	// single word transfer; entered just after a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask : wr
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000, rd);
		chk(rd, exp);
	endtask : rd_chk
	task complete_run();
		$display("comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	// ==========================================
	// main sequence
	initial begin
		n_errors = 0;
		n_tests  = 0;
		cycles   = 0;
		nrst     = 1'b0;
		hsel     = 1'b0;
		haddr    = 32'h00000000;
		htrans   = 2'h0;
		hwrite   = 1'b0;
		hsize    = 3'h2;
		hwdata   = 32'h00000000;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		// reset values, unmapped place and fixed response
		rd_chk(`OFS_MODE, 32'h00000000);
		rd_chk(`OFS_STATUS, 32'h00000000);
		rd_chk(`OFS_ANALOG, 32'h00000000);
		wr(`OFS_ANALOG, 32'hffffffff);
		rd_chk(`OFS_ANALOG, 32'h00000000);
		chk(32'({hreadyout, hresp}), 32'h00000002);
		// enable, settle past 1 us, then run on channel 2
		wr(`OFS_MASK, 32'h00000001);
		wr(`OFS_MODE, 32'h00000001);
		repeat (110) @(posedge ref_clk);
		wr(`OFS_CHAN, 32'h00000002);
		wr(`OFS_MODE, 32'h00000081);
		// a channel write landing on the first end of conversion wins: no flag, no interrupt
		repeat (4) @(posedge ref_clk);
		wr(`OFS_CHAN, 32'h00000002);
		rd_chk(`OFS_STATUS, 32'h00000000);
		chk(32'(irq), 32'h00000000);
		// the processor idles here while the converter keeps going
		repeat (12) @(posedge ref_clk);
		chk(32'({analog_channel, comparator_on}), 32'h00000005);
		rd_chk(`OFS_STATUS, 32'h00000001);
		chk(32'(irq), 32'h00000001);
		rd_chk(`OFS_RESULT, {16'h0000, 2'h2, 8'h3c, 6'h00});
		rd_chk(`OFS_RESULT_HI, {24'h000000, 2'h2, 6'h0f});
		// stop, then a channel change leaves the done flag alone
		wr(`OFS_MODE, 32'h00000000);
		rd_chk(`OFS_MODE, 32'h00000000);
		wr(`OFS_CHAN, 32'h00000001);
		rd_chk(`OFS_STATUS, 32'h00000001);
		// write one to clear before the restart
		wr(`OFS_STATUS, 32'h00000003);
		rd_chk(`OFS_STATUS, 32'h00000000);
		repeat (2) @(posedge ref_clk);
		chk(32'(irq), 32'h00000000);
		// start with the comparator off: first result marked suspect, interrupt masked off
		wr(`OFS_MASK, 32'h00000000);
		// the first result of this start is never read: it is stored, with the bad flag set as suspect
		wr(`OFS_MODE, 32'h00000080);
		repeat (12) @(posedge ref_clk);
		rd_chk(`OFS_STATUS, 32'h00000003);
		chk(32'(irq), 32'h00000000);
		wr(`OFS_MASK, 32'h00000002);
		repeat (2) @(posedge ref_clk);
		chk(32'(irq), 32'h00000001);
		wr(`OFS_MODE, 32'h00000000);
		wr(`OFS_STATUS, 32'h00000002);
		repeat (2) @(posedge ref_clk);
		chk(32'(irq), 32'h00000000);
		complete_run();
	end
endmodule : testbench
`default_nettype wire
